// ### rtl/cdb_top.sv
`timescale 1ns/1ns
`include "cdb_cfg.svh"
// Notes on behaviour
// - Half bridge: output A turns on after rising-edge dead band following input rise.
// - Full bridge: reverse dead band only on forward-to-reverse change, on output B.
// - Rising dead-band count spans 0 to 64 clock periods.
// - Dead band starts on the input edge; count zero gives no dead band.
// - Input reversing before count ends suppresses that output pulse.
// - Rising count double-buffered; with block disabled a write loads it at once.
// - Enabled: load after request, at first input rise following next fall.
// - Half bridge: output B turns on after falling-edge dead band following input fall.
// - Full bridge: forward dead band only on reverse-to-forward change, on output D.
// - Falling count spans 0 to 64 periods, starts on edge, zero adds nothing.
// - Falling count double-buffered; with block disabled a write loads it at once.
module cdb_top #(
    parameter int CNT_W = `CDB_CNT_W
) (
    input  wire logic                   sys_clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   ce_i,
    input  wire logic                   data_i,
    input  wire logic [`CDB_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic [7:0]                  rdata_o,
    output logic                        bridge_output_a_o,
    output logic                        bridge_output_b_o,
    output logic                        bridge_output_c_o,
    output logic                        bridge_output_d_o
);
    logic             en_r;
    logic             full_r;
    logic             rev_r;
    logic             buffer_load_request_r;
    logic [CNT_W-1:0] rise_deadband_count_r;
    logic [CNT_W-1:0] fall_deadband_count_r;
    logic [CNT_W-1:0] act_rise_r;
    logic [CNT_W-1:0] act_fall_r;
    logic             data_d_r;
    logic             rev_d_r;
    logic             fwd_hold_r;
    logic             rev_hold_r;
    cdb_pkg::cdb_ld_e ld_st_r;
    cdb_pkg::cdb_ld_e ld_st_nxt;
    logic [7:0]       rdata_nxt;

    logic dly_rise_out;
    logic dly_fall_out;

    function automatic logic [CNT_W-1:0] clamp_cnt(input logic [7:0] v);
        clamp_cnt = (v > 8'(`CDB_CNT_MAX)) ? CNT_W'(`CDB_CNT_MAX) : v[CNT_W-1:0];
    endfunction

    function automatic logic [7:0] pad_cnt(input logic [CNT_W-1:0] v);
        pad_cnt = {{(8-CNT_W){1'b0}}, v};
    endfunction

    wire wr_ctrl_w   = wr_i & (addr_i == `CDB_OFF_CTRL);
    wire wr_rise_w   = wr_i & (addr_i == `CDB_OFF_RISE);
    wire wr_fall_w   = wr_i & (addr_i == `CDB_OFF_FALL);
    wire data_rise_w = data_i & ~data_d_r;
    wire data_fall_w = ~data_i & data_d_r;
    wire transfer_w  = en_r & (ld_st_r == cdb_pkg::CDB_LD_WAIT_RISE) & data_rise_w;
    wire ld_set_w    = wr_ctrl_w & wdata_i[`CDB_CTRL_LD];

    // Direction changes: a fresh change restarts the dead band on the affected leg
    wire to_rev_w = rev_r & ~rev_d_r;
    wire to_fwd_w = ~rev_r & rev_d_r;

    // Half bridge: A follows rising delay, B follows falling delay of the inverse.
    // Full bridge: delay requests gate the modulated leg after direction change.
    wire req_rise_w = full_r ? (rev_r & ~to_rev_w & ~rev_hold_r) : data_i;
    wire req_fall_w = full_r ? (~rev_r & ~to_fwd_w & ~fwd_hold_r) : ~data_i;

    cdb_delay #(.CNT_W(CNT_W)) u_rise (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i | ~en_r),
        .ce_i      (ce_i),
        .req_i     (req_rise_w),
        .count_i   (act_rise_r),
        .out_o     (dly_rise_out)
    );

    cdb_delay #(.CNT_W(CNT_W)) u_fall (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i | ~en_r),
        .ce_i      (ce_i),
        .req_i     (req_fall_w),
        .count_i   (act_fall_r),
        .out_o     (dly_fall_out)
    );

    // Load sequencing: wait for fall, then the next rise
    always_comb begin
        ld_st_nxt = ld_st_r;
        unique case (ld_st_r)
            cdb_pkg::CDB_LD_IDLE:
                if (ld_set_w && en_r) ld_st_nxt = cdb_pkg::CDB_LD_WAIT_FALL;
            cdb_pkg::CDB_LD_WAIT_FALL:
                if (data_fall_w) ld_st_nxt = cdb_pkg::CDB_LD_WAIT_RISE;
            cdb_pkg::CDB_LD_WAIT_RISE:
                if (data_rise_w) ld_st_nxt = cdb_pkg::CDB_LD_IDLE;
            default:
                ld_st_nxt = cdb_pkg::CDB_LD_IDLE;
        endcase
        if (!en_r)
            ld_st_nxt = cdb_pkg::CDB_LD_IDLE;
    end

    always_comb begin
        unique case (addr_i)
            `CDB_OFF_CTRL:     rdata_nxt = {4'h0, buffer_load_request_r, rev_r, full_r, en_r};
            `CDB_OFF_RISE:     rdata_nxt = pad_cnt(rise_deadband_count_r);
            `CDB_OFF_FALL:     rdata_nxt = pad_cnt(fall_deadband_count_r);
            `CDB_OFF_STATUS:   rdata_nxt = {3'h0, buffer_load_request_r, bridge_output_d_o,
                                            bridge_output_c_o, bridge_output_b_o,
                                            bridge_output_a_o};
            `CDB_OFF_ACT_RISE: rdata_nxt = pad_cnt(act_rise_r);
            `CDB_OFF_ACT_FALL: rdata_nxt = pad_cnt(act_fall_r);
            default:           rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            en_r   <= 1'b0;
            full_r <= 1'b0;
            rev_r  <= 1'b0;
        end else if (ce_i && wr_ctrl_w) begin
            en_r   <= wdata_i[`CDB_CTRL_EN];
            full_r <= wdata_i[`CDB_CTRL_FULL];
            rev_r  <= wdata_i[`CDB_CTRL_REV];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rise_deadband_count_r <= `CDB_CNT_RST;
            fall_deadband_count_r <= `CDB_CNT_RST;
        end else if (ce_i) begin
            if (wr_rise_w) rise_deadband_count_r <= clamp_cnt(wdata_i);
            if (wr_fall_w) fall_deadband_count_r <= clamp_cnt(wdata_i);
        end
    end

    // Disabled: writes pass straight to the active copy
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            act_rise_r <= `CDB_CNT_RST;
            act_fall_r <= `CDB_CNT_RST;
        end else if (ce_i) begin
            if (!en_r && wr_rise_w) act_rise_r <= clamp_cnt(wdata_i);
            else if (transfer_w)    act_rise_r <= rise_deadband_count_r;
            if (!en_r && wr_fall_w) act_fall_r <= clamp_cnt(wdata_i);
            else if (transfer_w)    act_fall_r <= fall_deadband_count_r;
        end
    end

    // Set wins over the hardware clear
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            buffer_load_request_r <= 1'b0;
            ld_st_r               <= cdb_pkg::CDB_LD_IDLE;
        end else if (ce_i) begin
            ld_st_r <= ld_st_nxt;
            if (ld_set_w && en_r)
                buffer_load_request_r <= 1'b1;
            else if (transfer_w || !en_r)
                buffer_load_request_r <= 1'b0;
        end
    end

    // Hold the new leg off for two cycles at a direction change so the delay restarts
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            data_d_r   <= 1'b0;
            rev_d_r    <= 1'b0;
            fwd_hold_r <= 1'b0;
            rev_hold_r <= 1'b0;
        end else if (ce_i) begin
            data_d_r   <= data_i;
            rev_d_r    <= rev_r;
            fwd_hold_r <= to_fwd_w;
            rev_hold_r <= to_rev_w;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdata_o           <= 8'h00;
            bridge_output_a_o <= 1'b0;
            bridge_output_b_o <= 1'b0;
            bridge_output_c_o <= 1'b0;
            bridge_output_d_o <= 1'b0;
        end else if (ce_i) begin
            rdata_o <= rd_i ? rdata_nxt : 8'h00;
            if (full_r) begin
                // Forward: A on, D modulated. Reverse: C on, B modulated.
                // The live request drops the modulated leg on the same edge that the
                // steady leg switches, so a stale delay output cannot overlap them.
                bridge_output_a_o <= en_r & ~rev_r;
                bridge_output_b_o <= en_r & dly_rise_out & req_rise_w & data_i;
                bridge_output_c_o <= en_r & rev_r;
                bridge_output_d_o <= en_r & dly_fall_out & req_fall_w & data_i;
            end else begin
                bridge_output_a_o <= en_r & dly_rise_out;
                bridge_output_b_o <= en_r & dly_fall_out;
                bridge_output_c_o <= en_r & dly_rise_out;
                bridge_output_d_o <= en_r & dly_fall_out;
            end
        end
    end
endmodule

// ### rtl/cdb_cfg.svh
`ifndef CDB_CFG_SVH
`define CDB_CFG_SVH
// Register offsets on the plain register port
`define CDB_ADDR_W        4
`define CDB_OFF_CTRL      4'h0
`define CDB_OFF_RISE      4'h1
`define CDB_OFF_FALL      4'h2
`define CDB_OFF_STATUS    4'h3
`define CDB_OFF_ACT_RISE  4'h4
`define CDB_OFF_ACT_FALL  4'h5
// Control fields
`define CDB_CTRL_EN       0
`define CDB_CTRL_FULL     1
`define CDB_CTRL_REV      2
`define CDB_CTRL_LD       3
// Status fields
`define CDB_STAT_A        0
`define CDB_STAT_B        1
`define CDB_STAT_C        2
`define CDB_STAT_D        3
`define CDB_STAT_LD       4
// Count width and limit
`define CDB_CNT_W         7
`define CDB_CNT_MAX       7'h40
`define CDB_CNT_RST       7'h00
`endif

// ### rtl/cdb_pkg.sv
package cdb_pkg;
    typedef enum logic [1:0] {
        CDB_LD_IDLE = 2'b00,
        CDB_LD_WAIT_FALL = 2'b01,
        CDB_LD_WAIT_RISE = 2'b10
    } cdb_ld_e;
endpackage

// ### rtl/cdb_delay.sv
`timescale 1ns/1ns
`include "cdb_cfg.svh"
// Delays the rising edge of a request level by a count of clocks.
// A falling request before the count ends cancels the pulse entirely.
module cdb_delay #(
    parameter int CNT_W = `CDB_CNT_W
) (
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    input  wire logic             ce_i,
    input  wire logic             req_i,
    input  wire logic [CNT_W-1:0] count_i,
    output logic                  out_o
);
    logic [CNT_W-1:0] cnt_r;
    logic             req_d_r;
    wire              rise_w = req_i & ~req_d_r;
    wire              zero_w = (count_i == '0);

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cnt_r   <= '0;
            req_d_r <= 1'b0;
            out_o   <= 1'b0;
        end else if (ce_i) begin
            req_d_r <= req_i;
            if (!req_i) begin
                out_o <= 1'b0;
                cnt_r <= '0;
            end else if (rise_w) begin
                out_o <= zero_w;
                cnt_r <= count_i;
            end else if (!out_o) begin
                if (cnt_r <= CNT_W'(1))
                    out_o <= 1'b1;
                cnt_r <= (cnt_r == '0) ? '0 : cnt_r - CNT_W'(1);
            end
        end
    end
endmodule

// ### bench/cdb_bridge_drv.sv
`timescale 1ns/1ns
// Switch driver pair: counts cycles where both switches of one leg are on
module cdb_bridge_drv (
    input  wire logic sys_clk_i,
    input  wire logic a_i,
    input  wire logic b_i,
    input  wire logic c_i,
    input  wire logic d_i,
    output int        shoot_o
);
    int cnt_r = 0;
    assign shoot_o = cnt_r;
    always @(posedge sys_clk_i) begin
        if ((a_i && b_i) || (c_i && d_i)) begin
            cnt_r <= cnt_r + 1;
        end
    end
endmodule

// ### bench/cdb_chk.sv
`timescale 1ns/1ns
`include "cdb_cfg.svh"
module cdb_chk #(
    parameter int CNT_W = `CDB_CNT_W
) (
    input wire logic                   sys_clk_i,
    input wire logic                   reset_i,
    input wire logic                   ce_i,
    input wire logic                   data_i,
    input wire logic [`CDB_ADDR_W-1:0] addr_i,
    input wire logic [7:0]             wdata_i,
    input wire logic                   wr_i,
    input wire logic                   rd_i,
    input wire logic [7:0]             rdata_o,
    input wire logic                   bridge_output_a_o,
    input wire logic                   bridge_output_b_o,
    input wire logic                   bridge_output_c_o,
    input wire logic                   bridge_output_d_o
);
    logic [2:0] ctl_r;
    logic [2:0] ctl_q;
    logic [2:0] ctl_q2;
    wire        a = bridge_output_a_o;
    wire        b = bridge_output_b_o;
    wire        c = bridge_output_c_o;
    wire        d = bridge_output_d_o;
    // Mode must sit still for two cycles so the output stage has caught up
    wire        settled = (ctl_r == ctl_q) && (ctl_q == ctl_q2);
    wire        hb = settled && ctl_r[0] && !ctl_r[1];
    wire        fwd = settled && (ctl_r == 3'h3);
    wire        rvs = settled && (ctl_r == 3'h7);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ctl_r <= 3'h0;
            ctl_q <= 3'h0;
            ctl_q2 <= 3'h0;
        end else begin
            if (ce_i && wr_i && addr_i == `CDB_OFF_CTRL) begin
                ctl_r <= wdata_i[2:0];
            end
            ctl_q <= ctl_r;
            ctl_q2 <= ctl_q;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    property p_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
    property p_a_cause; hb && $rose(a) |-> $past(data_i); endproperty
    property p_b_cause; hb && $rose(b) |-> !$past(data_i); endproperty
    property p_a_cancel; hb && !$past(data_i, 2) && !$past(data_i) |-> !a; endproperty
    property p_b_cancel; hb && $past(data_i, 2) && $past(data_i) |-> !b; endproperty
    property p_mirror; hb |-> c == a && d == b; endproperty
    property p_fwd; fwd |-> a && !b && !c; endproperty
    property p_rev; rvs |-> c && !a && !d; endproperty
    property p_d_cause; fwd && $rose(d) |-> $past(data_i); endproperty
    a_idle: assert property (p_idle)
        else $error("read data seen outside a read");
    a_a_cause: assert property (p_a_cause)
        else $error("output a rose without data high");
    a_b_cause: assert property (p_b_cause)
        else $error("output b rose without data low");
    a_a_cancel: assert property (p_a_cancel)
        else $error("output a on while data low");
    a_b_cancel: assert property (p_b_cancel)
        else $error("output b on while data high");
    a_mirror: assert property (p_mirror)
        else $error("half bridge c or d not mirroring");
    a_fwd: assert property (p_fwd)
        else $error("forward mode outputs wrong");
    a_rev: assert property (p_rev)
        else $error("reverse mode outputs wrong");
    a_d_cause: assert property (p_d_cause)
        else $error("output d rose without data high");
    c_a_on: cover property ($rose(a));
    c_d_on: cover property ($rose(d));
    c_read: cover property (rd_i ##1 rdata_o != 8'h00);
endmodule
bind cdb_top cdb_chk #(.CNT_W(CNT_W)) u_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .ce_i(ce_i), .data_i(data_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .bridge_output_a_o(bridge_output_a_o),
    .bridge_output_b_o(bridge_output_b_o), .bridge_output_c_o(bridge_output_c_o),
    .bridge_output_d_o(bridge_output_d_o));

// ### bench/complementary_deadband_insertion_test.sv
`timescale 1ns/1ns
`include "cdb_cfg.svh"
module complementary_deadband_insertion_test;
    logic       sys_clk_i = 0, reset_i = 1, data_i = 0, wr_i = 0, rd_i = 0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, rd_v;
    logic       oa, ob, oc, od, seen;
    int         n_fail = 0, comparisons = 0, cyc = 0, shoot, k;
    wire  [3:0] outs = {od, oc, ob, oa};
    cdb_top dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .ce_i(1'b1), .data_i(data_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .bridge_output_a_o(oa), .bridge_output_b_o(ob), .bridge_output_c_o(oc),
        .bridge_output_d_o(od));
    cdb_bridge_drv drv (.sys_clk_i(sys_clk_i), .a_i(oa), .b_i(ob), .c_i(oc), .d_i(od),
        .shoot_o(shoot));
    initial forever #10 sys_clk_i = ~sys_clk_i;
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 rd_v = rdata_o;
    endtask
    task automatic drive(input logic v);
        @(posedge sys_clk_i);
        data_i <= v;
    endtask
    // Edges from the data change until the chosen output is on
    task automatic lat(input int sel);
        k = 0;
        while (k < 200 && outs[sel] !== 1'b1) begin
            @(posedge sys_clk_i);
            #1 k++;
        end
    endtask
    task automatic pulse(input logic v, input int sel);
        drive(v);
        repeat (5) @(posedge sys_clk_i);
        drive(!v);
        seen = 1'b0;
        repeat (20) @(posedge sys_clk_i) #1 seen |= outs[sel];
        check(8'(seen), 8'h00);
    endtask
    task automatic t_half();
        logic [7:0] cs [4] = '{8'h00, 8'h01, 8'h40, 8'h64};
        logic [7:0] e;
        for (int i = 0; i < 4; i++) begin
            e = (cs[i] > 8'h40) ? 8'h40 : cs[i];
            wr(`CDB_OFF_CTRL, 8'h00);
            wr(`CDB_OFF_RISE, cs[i]);
            wr(`CDB_OFF_FALL, cs[i]);
            rd(`CDB_OFF_ACT_RISE);
            check(rd_v, e);
            rd(`CDB_OFF_ACT_FALL);
            check(rd_v, e);
            wr(`CDB_OFF_CTRL, 8'h01);
            lat(1);
            drive(1'b1);
            lat(0);
            check(8'(k), e + 8'h02);
            drive(1'b0);
            lat(1);
            check(8'(k), e + 8'h02);
        end
        $display("half bridge test done");
    endtask
    task automatic t_load();
        wr(`CDB_OFF_CTRL, 8'h00);
        wr(`CDB_OFF_RISE, 8'h0a);
        wr(`CDB_OFF_FALL, 8'h0a);
        wr(`CDB_OFF_CTRL, 8'h01);
        repeat (20) @(posedge sys_clk_i);
        pulse(1'b1, 0);
        drive(1'b1);
        repeat (20) @(posedge sys_clk_i);
        pulse(1'b0, 1);
        // Data low while the request is set, so the next rise precedes any fall
        drive(1'b0);
        wr(`CDB_OFF_RISE, 8'h03);
        wr(`CDB_OFF_FALL, 8'h05);
        wr(`CDB_OFF_CTRL, 8'h09);
        rd(`CDB_OFF_STATUS);
        check({7'h00, rd_v[4]}, 8'h01);
        // A rise before any fall must not load the new counts
        drive(1'b1);
        repeat (15) @(posedge sys_clk_i);
        rd(`CDB_OFF_ACT_RISE);
        check(rd_v, 8'h0a);
        drive(1'b0);
        repeat (15) @(posedge sys_clk_i);
        rd(`CDB_OFF_ACT_RISE);
        check(rd_v, 8'h0a);
        drive(1'b1);
        repeat (15) @(posedge sys_clk_i);
        rd(`CDB_OFF_ACT_FALL);
        check(rd_v, 8'h05);
        rd(`CDB_OFF_ACT_RISE);
        check(rd_v, 8'h03);
        rd(`CDB_OFF_STATUS);
        check({7'h00, rd_v[4]}, 8'h00);
        $display("load test done");
    endtask
    task automatic t_full();
        wr(`CDB_OFF_CTRL, 8'h03);
        repeat (10) @(posedge sys_clk_i);
        wr(`CDB_OFF_CTRL, 8'h07);
        lat(1);
        check(8'(k >= 3 && k <= 8), 8'h01);
        wr(`CDB_OFF_CTRL, 8'h03);
        lat(3);
        check(8'(k >= 5 && k <= 10), 8'h01);
        $display("full bridge test done");
    endtask
    task automatic stop_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        for (int a = 0; a < 7; a++) begin
            rd((a == 6) ? 4'hf : 4'(a));
            check(rd_v, 8'h00);
        end
        t_half();
        t_load();
        t_full();
        check(8'(shoot), 8'h00);
        stop_test();
    end
endmodule
